// ===== rtl/sbt_pkg.sv
// Constants and carrier types for the memory test access port.
// Assumes a test controller on the board that drives the test clock, mode select and data in.
package sbt_pkg;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 68;

  localparam logic [2:0] INS_EXT = 3'h0;
  localparam logic [2:0] INS_IDN = 3'h1;
  localparam logic [2:0] INS_SMZ = 3'h2;
  localparam logic [2:0] INS_SMP = 3'h4;
  localparam logic [2:0] INS_BYP = 3'h7;
  localparam logic [2:0] IR_RESET = INS_IDN;
  localparam logic [1:0] IR_CAPT = 2'h1;

  // Identification field values; maker and device codes are arbitrary
  localparam logic [3:0] ID_VER = 4'h0;
  localparam logic [4:0] ID_DEPTH = 5'h07;
  localparam logic [4:0] ID_WIDTH = 5'h03;
  localparam logic [5:0] ID_DEVNUM = 6'h00;
  localparam logic [10:0] ID_MAKER = 11'h2a5;
  localparam logic ID_PRESENT = 1'b1;

  typedef enum logic [15:0] {
    ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SDS = 16'h0004, ST_CDR = 16'h0008,
    ST_SDR = 16'h0010, ST_E1D = 16'h0020, ST_PDR = 16'h0040, ST_E2D = 16'h0080,
    ST_UDR = 16'h0100, ST_SIS = 16'h0200, ST_CIR = 16'h0400, ST_SIR = 16'h0800,
    ST_E1I = 16'h1000, ST_PIR = 16'h2000, ST_E2I = 16'h4000, ST_UIR = 16'h8000
  } sbt_state_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } sbt_serial_t;

endpackage

// ===== rtl/sbt_tap.sv
// Test access port of the memory: controller, instruction, bypass, identification, scan chain.
// Assumes the ring inputs come from the memory clock domain; CLK is only used for float control.
`timescale 1ns/1ns
module sbt_tap
  import sbt_pkg::*;
#(
  parameter int BSR_LEN = sbt_pkg::BSR_W
) (
  CLK,       // Memory clock
  ARST_N,    // Asynchronous reset, active low
  TCK,       // Test clock
  TMS,       // Mode select
  TDI,       // Serial data in
  RING,      // I/O ring values to capture
  SERIAL,    // Serial out and its enable
  FLOAT_Q    // Memory output drivers float, synced to CLK
);
  input wire logic CLK;
  input wire logic ARST_N;
  input wire logic TCK;
  input wire logic TMS;
  input wire logic TDI;
  input wire logic [BSR_LEN-1:0] RING;
  output sbt_pkg::sbt_serial_t SERIAL;
  output logic FLOAT_Q;

  initial begin
    if (BSR_LEN < 2) $error("BSR_LEN too small");
  end

  // ---------------------------------------------------------------
  // Identification word
  // ---------------------------------------------------------------
  localparam logic [ID_W-1:0] ID_WORD = {ID_VER, ID_DEPTH, ID_WIDTH, ID_DEVNUM,
                                         ID_MAKER, ID_PRESENT};

  // ---------------------------------------------------------------
  // Controller, rising test clock
  // ---------------------------------------------------------------
  sbt_state_t st_r, st_nxt;
  logic [IR_W-1:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  logic byp_r, byp_nxt;
  logic [ID_W-1:0] id_r, id_nxt;
  logic [BSR_LEN-1:0] bsr_r, bsr_nxt;
  logic [BSR_LEN-1:0] ring_s1_r, ring_s2_r;
  logic float_r, float_nxt;

  function automatic logic is_scan(input logic [IR_W-1:0] ins);
    is_scan = (ins == INS_EXT) || (ins == INS_SMZ) || (ins == INS_SMP);
  endfunction

  // Ring inputs come from the memory domain and are resynced before capture
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ring_s1_r <= '0;
      ring_s2_r <= '0;
    end else begin
      ring_s1_r <= RING;
      ring_s2_r <= ring_s1_r;
    end
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_TLR: st_nxt = TMS ? ST_TLR : ST_RTI;
      ST_RTI: st_nxt = TMS ? ST_SDS : ST_RTI;
      ST_SDS: st_nxt = TMS ? ST_SIS : ST_CDR;
      ST_CDR: st_nxt = TMS ? ST_E1D : ST_SDR;
      ST_SDR: st_nxt = TMS ? ST_E1D : ST_SDR;
      ST_E1D: st_nxt = TMS ? ST_UDR : ST_PDR;
      ST_PDR: st_nxt = TMS ? ST_E2D : ST_PDR;
      ST_E2D: st_nxt = TMS ? ST_UDR : ST_SDR;
      ST_UDR: st_nxt = TMS ? ST_SDS : ST_RTI;
      ST_SIS: st_nxt = TMS ? ST_TLR : ST_CIR;
      ST_CIR: st_nxt = TMS ? ST_E1I : ST_SIR;
      ST_SIR: st_nxt = TMS ? ST_E1I : ST_SIR;
      ST_E1I: st_nxt = TMS ? ST_UIR : ST_PIR;
      ST_PIR: st_nxt = TMS ? ST_E2I : ST_PIR;
      ST_E2I: st_nxt = TMS ? ST_UIR : ST_SIR;
      ST_UIR: st_nxt = TMS ? ST_SDS : ST_RTI;
      default: st_nxt = ST_TLR;
    endcase
  end

  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    id_nxt = id_r;
    bsr_nxt = bsr_r;
    case (st_r)
      ST_TLR: begin
        ir_nxt = IR_RESET;
      end
      ST_CIR: begin
        ir_sh_nxt = {1'b0, IR_CAPT};
      end
      ST_SIR: begin
        ir_sh_nxt = {TDI, ir_sh_r[IR_W-1:1]};
      end
      ST_UIR: begin
        ir_nxt = ir_sh_r;
      end
      ST_CDR: begin
        if (is_scan(ir_r)) bsr_nxt = ring_s2_r;
        else if (ir_r == INS_IDN) id_nxt = ID_WORD;
        else byp_nxt = 1'b0;
      end
      ST_SDR: begin
        if (is_scan(ir_r)) bsr_nxt = {TDI, bsr_r[BSR_LEN-1:1]};
        else if (ir_r == INS_IDN) id_nxt = {TDI, id_r[ID_W-1:1]};
        else byp_nxt = TDI;
      end
      default: begin
      end
    endcase
    // Load on entry to Test-Logic-Reset, so the test clock may stop right after a reset
    if (st_nxt == ST_TLR) ir_nxt = IR_RESET;
  end

  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= ST_TLR;
      ir_sh_r <= '0;
      ir_r <= IR_RESET;
      byp_r <= 1'b0;
      id_r <= '0;
      bsr_r <= '0;
    end else begin
      st_r <= st_nxt;
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      id_r <= id_nxt;
      bsr_r <= bsr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Serial output, falling test clock
  // ---------------------------------------------------------------
  sbt_serial_t ser_r, ser_nxt;

  always_comb begin
    ser_nxt.tdo = 1'b0;
    ser_nxt.tdo_oe_n = 1'b1;
    if (st_r == ST_SIR) begin
      ser_nxt.tdo = ir_sh_r[0];
      ser_nxt.tdo_oe_n = 1'b0;
    end else if (st_r == ST_SDR) begin
      ser_nxt.tdo_oe_n = 1'b0;
      if (is_scan(ir_r)) ser_nxt.tdo = bsr_r[0];
      else if (ir_r == INS_IDN) ser_nxt.tdo = id_r[0];
      else ser_nxt.tdo = byp_r;
    end
  end

  always_ff @(negedge TCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ser_r <= '{tdo: 1'b0, tdo_oe_n: 1'b1};
    end else begin
      ser_r <= ser_nxt;
    end
  end

  assign SERIAL = ser_r;

  // ---------------------------------------------------------------
  // Output float, crossed to the memory clock
  // ---------------------------------------------------------------
  // Float holds from Update-IR until another instruction; a level, so two flops suffice
  always_comb begin
    // Taken from the next instruction so the level needs no further test clock edge
    float_nxt = (ir_nxt == INS_EXT) || (ir_nxt == INS_SMZ);
  end

  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) float_r <= 1'b0;
    else float_r <= float_nxt;
  end

  logic fl_s1_r, fl_s2_r;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fl_s1_r <= 1'b0;
      fl_s2_r <= 1'b0;
    end else begin
      fl_s1_r <= float_r;
      fl_s2_r <= fl_s1_r;
    end
  end

  assign FLOAT_Q = fl_s2_r;

endmodule // sbt_tap

// ===== verif/sbt_jtag_model.sv
// Board scan controller: makes the test clock only while it steps.
// Assumes the port sits in Run-Test/Idle between scans.
`timescale 1ns/1ns
module sbt_jtag_model (
  output logic TCK, // Test clock, idles low
  output logic TMS, // Mode select
  output logic TDI, // Serial data to the port
  input wire logic TDO // Serial data from the port
);
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // Drive after the fall, sample before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    #1 TMS = tms;
    TDI = tdi;
    #2 tdo = TDO;
    TCK = 1'b1;
    #3 TCK = 1'b0;
  endtask
  // Clock stands still after the five highs so the float sync settles
  task automatic reset5();
    logic d;
    repeat (5) step(1'b1, ~TDI, d);
    #300 step(1'b0, ~TDI, d);
  endtask
  // Instruction or data scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic d;
    dout = '0;
    step(1'b1, ~TDI, d);
    if (ir) step(1'b1, ~TDI, d);
    step(1'b0, ~TDI, d);
    step(1'b0, ~TDI, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, ~TDI, d);
    step(1'b0, ~TDI, d);
  endtask
endmodule // sbt_jtag_model

// ===== verif/sbt_tap_checker.sv
// Assertions on the pins of the memory test access port.
// Assumes the test clock idles low between frames.
`timescale 1ns/1ns
module sbt_tap_checker
  import sbt_pkg::*;
#(
  parameter int BSR_LEN = 68
) (
  input logic CLK, // Memory clock
  input logic ARST_N, // Reset, active low
  input logic TCK, // Test clock
  input logic TMS, // Mode select
  input logic TDI, // Serial in
  input logic [BSR_LEN-1:0] RING, // Ring values
  input sbt_pkg::sbt_serial_t SERIAL, // Serial out
  input logic FLOAT_Q // Outputs float
);
  // Run of mode-select highs, saturating at five
  logic [2:0] hi_cnt_r;
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) hi_cnt_r <= 3'h0;
    else hi_cnt_r <= !TMS ? 3'h0 : (hi_cnt_r == 3'h5 ? 3'h5 : hi_cnt_r + 3'h1);
  end
  // Test clock activity seen from the memory clock; an even number of rising edges between samples goes unseen
  logic tog_r, tog_q_r;
  logic [2:0] quiet_r;
  always_ff @(posedge TCK or negedge ARST_N) begin
    if (!ARST_N) tog_r <= 1'b0;
    else tog_r <= !tog_r;
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tog_q_r <= 1'b0;
      quiet_r <= 3'h0;
    end else begin
      tog_q_r <= tog_r;
      quiet_r <= (tog_r != tog_q_r) ? 3'h0 : (quiet_r == 3'h7 ? 3'h7 : quiet_r + 3'h1);
    end
  end
  a_idle_tdo_low:
    assert property (@(posedge TCK) disable iff (!ARST_N) SERIAL.tdo_oe_n |-> !SERIAL.tdo)
    else $error("tdo not low while idle");
  a_five_high_idle:
    assert property (@(posedge TCK) disable iff (!ARST_N) TMS [*5] |=> SERIAL.tdo_oe_n)
    else $error("port not reset by five highs");
  a_reset_unfloat:
    assert property (@(posedge CLK) disable iff (!ARST_N) (hi_cnt_r == 3'h5) [*5] |-> !FLOAT_Q)
    else $error("float stays after port reset");
  a_release_state:
    assert property (@(posedge CLK) disable iff (!ARST_N)
      $rose(ARST_N) |-> !FLOAT_Q && SERIAL.tdo_oe_n)
    else $error("wrong state after reset");
  a_float_steady:
    assert property (@(posedge CLK) disable iff (!ARST_N) quiet_r >= 3'h3 |-> $stable(FLOAT_Q))
    else $error("float moved without test clock");
  a_shift_entry:
    assert property (@(posedge TCK) disable iff (!ARST_N) $fell(SERIAL.tdo_oe_n) |-> !$past(TMS))
    else $error("shift entered with mode high");
  a_shift_exit:
    assert property (@(posedge TCK) disable iff (!ARST_N) $rose(SERIAL.tdo_oe_n) |-> $past(TMS))
    else $error("shift left with mode low");
  a_shift_hold:
    assert property (@(posedge TCK) disable iff (!ARST_N)
      !SERIAL.tdo_oe_n && !TMS |=> !SERIAL.tdo_oe_n)
    else $error("shift dropped early");
  c_shift: cover property (@(posedge TCK) $fell(SERIAL.tdo_oe_n));
  c_float: cover property (@(posedge CLK) $rose(FLOAT_Q));
  c_reset: cover property (@(posedge TCK) TMS [*5]);
endmodule // sbt_tap_checker

bind sbt_tap sbt_tap_checker #(.BSR_LEN(BSR_LEN)) i_chk (.CLK(CLK), .ARST_N(ARST_N),
  .TCK(TCK), .TMS(TMS), .TDI(TDI), .RING(RING), .SERIAL(SERIAL), .FLOAT_Q(FLOAT_Q));

// ===== verif/sbt_tap_tb.sv
// Self-checking bench for the memory test access port.
// Assumes the controller model drives the test pins.
`timescale 1ns/1ns
module sbt_tap_tb;
  import sbt_pkg::*;
  localparam int BL = 8;
  localparam logic [31:0] ID_EXP = {ID_VER, ID_DEPTH, ID_WIDTH, ID_DEVNUM, ID_MAKER, 1'b1};
  logic clk, arst_n, b;
  logic [BL-1:0] ring;
  sbt_serial_t serial;
  logic float_q;
  wire tck, tms, tdi;
  int errors = 0, n_compared = 0, cyc = 0;
  logic [127:0] q;
  sbt_tap #(.BSR_LEN(BL)) i_dut (.CLK(clk), .ARST_N(arst_n), .TCK(tck), .TMS(tms),
    .TDI(tdi), .RING(ring), .SERIAL(serial), .FLOAT_Q(float_q));
  sbt_jtag_model i_ctl (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(serial.tdo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  task automatic t_id();
    i_ctl.scan(1'b0, 32, '0, q);
    check(q, ID_EXP);
    i_ctl.scan(1'b1, 3, INS_BYP, q);
    check(q[1:0], 2'h1);
  endtask
  task automatic t_byp();
    i_ctl.scan(1'b0, 8, 128'ha5, q);
    check(q[7:0], 8'h4a);
  endtask
  task automatic t_ring();
    logic [2:0] c [3] = '{INS_EXT, INS_SMZ, INS_SMP}; // Scan-chain instructions, each captures the ring
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      #2 ring = 8'h3c ^ 8'(k);
      i_ctl.scan(1'b1, 3, c[k], q);
      i_ctl.scan(1'b0, BL, '0, q);
      check(q[BL-1:0], ring);
      repeat (4) @(posedge clk);
      #2 check(float_q, c[k] != INS_SMP);
    end
  endtask
  task automatic t_rst();
    i_ctl.scan(1'b1, 3, INS_EXT, q);
    repeat (4) @(posedge clk);
    #2 check(float_q, 1'b1);
    i_ctl.reset5();
    check(float_q, 1'b0);
    i_ctl.scan(1'b0, 32, '0, q);
    check(q[31:0], ID_EXP);
  endtask
  initial begin
    arst_n = 1'b0;
    ring = '0;
    i_ctl.step(1'b1, 1'b0, b);
    repeat (12) @(posedge clk);
    #2 arst_n = 1'b1;
    i_ctl.reset5();
    t_id();
    t_byp();
    t_ring();
    t_rst();
    results();
  end
endmodule // sbt_tap_tb
